// File: common/usf_pkg.sv
// Shared types and constants of the serial transceiver core
package usf_pkg;

    // ********************************************************
    // Mode word layout, bit 7 down to bit 0
    // ********************************************************
    typedef struct packed {
        logic [1:0] stop;     // Async stop bits, sync method in sync mode
        logic       even;     // Even parity when set
        logic       par_en;   // Parity bit present
        logic [1:0] len;      // 00..11 give 5..8 data bits
        logic [1:0] factor;   // 00 sync, 01 1x, 10 16x, 11 64x
    } usf_mode_t;

    // Command word layout, bit 7 down to bit 0
    typedef struct packed {
        logic enter_hunt_bit;
        logic internal_reset_bit;
        logic rts;
        logic error_reset_bit;
        logic send_break_bit;
        logic rx_ready_enable;
        logic dtr;
        logic tx_enable_bit;
    } usf_cmd_t;

    // Status byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic dsr;
        logic sync_det;
        logic framing_error_flag;
        logic overrun_flag;
        logic parity_error_flag;
        logic tx_shifter_empty;
        logic rx_char_ready;
        logic tx_buffer_ready;
    } usf_status_t;

    // ********************************************************
    // Field codes and reset values
    // ********************************************************
    localparam logic [1:0] USF_FAC_SYNC  = 2'h0;
    localparam logic [1:0] USF_FAC_X1    = 2'h1;
    localparam logic [1:0] USF_FAC_X16   = 2'h2;
    localparam logic [1:0] USF_STOP_HALF = 2'h2;
    localparam logic [3:0] USF_LEN_BASE  = 4'h5;
    localparam logic [5:0] USF_TICKS_X1  = 6'h00;  // Ticks per bit, less one
    localparam logic [5:0] USF_TICKS_X16 = 6'h0F;
    localparam logic [5:0] USF_TICKS_X64 = 6'h3F;
    localparam logic [7:0] USF_MODE_RST  = 8'h00;
    localparam logic [7:0] USF_CMD_RST   = 8'h00;
    localparam int         USF_FIFO_W    = 8;
    localparam int         USF_FIFO_D    = 16;

    // Control-port sequencer states
    typedef enum logic [3:0] {
        USF_SEQ_MODE  = 4'h1,
        USF_SEQ_SYNC1 = 4'h2,
        USF_SEQ_SYNC2 = 4'h4,
        USF_SEQ_CMD   = 4'h8
    } usf_seq_t;

    // Receiver states
    typedef enum logic [2:0] {
        USF_RX_IDLE  = 3'h1,
        USF_RX_START = 3'h2,
        USF_RX_BITS  = 3'h4
    } usf_rx_t;

endpackage

// File: hw/usf_core.sv
// Serial transceiver core: control sequencer, framing, FIFO
`timescale 1ns/1ps

// ************************************************************
// Transmit FIFO
// ************************************************************
module usf_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_flush,
    // Filling side
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    // Draining side
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic      [W-1:0] o_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    // Honest flags from the occupancy count
    assign o_ready = (cnt != (AW+1)'(D));
    assign o_valid = (cnt != '0);
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;
    assign o_data  = mem[rp];

    // Storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp] <= i_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else if (i_flush) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ************************************************************
// Transceiver top
// ************************************************************
module usf_core (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Processor port
    input  wire logic        i_cs_n,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_cd,
    input  wire logic [7:0]  i_data,
    output logic      [7:0]  o_data,
    output logic             o_data_oe,
    // Ready indications
    output logic             o_tx_buffer_ready,
    output logic             o_rx_char_ready,
    output logic             o_tx_shifter_empty,
    // Serial line and bit clocks
    input  wire logic        i_tx_bit_clock_n,
    input  wire logic        i_rx_bit_clock_n,
    input  wire logic        i_rxd,
    output logic             o_txd,
    // Modem control
    input  wire logic        i_cts_n,
    input  wire logic        i_dsr_n,
    output logic             o_dtr_n,
    output logic             o_rts_n
);
    import usf_pkg::*;

    // ********************************************************
    // Processor strobes
    // ********************************************************
    logic        wr_q;
    logic        rd_q;
    logic        wr_go;
    logic        rd_go;
    logic        ctl_wr;
    logic        dat_wr;
    logic        soft_rst;
    usf_seq_t    seq;
    usf_mode_t   mode;
    usf_cmd_t    cmd;
    usf_cmd_t    new_cmd;
    logic [7:0]  sync1;
    logic [7:0]  sync2;

    // One pulse at the start of each access
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= ~i_cs_n & ~i_wr_n;
            rd_q <= ~i_cs_n & ~i_rd_n;
        end
    end

    assign wr_go    = ~i_cs_n & ~i_wr_n & ~wr_q;
    assign rd_go    = ~i_cs_n & ~i_rd_n & ~rd_q;
    assign ctl_wr   = wr_go & i_cd;
    assign dat_wr   = wr_go & ~i_cd;
    assign new_cmd  = usf_cmd_t'(i_data);
    assign soft_rst = ctl_wr & (seq == USF_SEQ_CMD)
                    & new_cmd.internal_reset_bit;

    // ********************************************************
    // Control-word sequencer
    // ********************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            seq <= USF_SEQ_MODE;
        end else if (ctl_wr) begin
            case (seq)
                USF_SEQ_MODE: begin
                    if (i_data[1:0] == USF_FAC_SYNC) begin
                        seq <= USF_SEQ_SYNC1;
                    end else begin
                        seq <= USF_SEQ_CMD;
                    end
                end
                USF_SEQ_SYNC1: begin
                    if (mode.stop[1]) begin
                        seq <= USF_SEQ_CMD;
                    end else begin
                        seq <= USF_SEQ_SYNC2;
                    end
                end
                USF_SEQ_SYNC2: seq <= USF_SEQ_CMD;
                USF_SEQ_CMD: begin
                    if (new_cmd.internal_reset_bit) begin
                        seq <= USF_SEQ_MODE;
                    end
                end
                default: seq <= USF_SEQ_MODE;
            endcase
        end
    end

    // Mode word and sync characters
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode  <= usf_mode_t'(USF_MODE_RST);
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else if (ctl_wr) begin
            if (seq == USF_SEQ_MODE) begin
                mode <= usf_mode_t'(i_data);
            end
            if (seq == USF_SEQ_SYNC1) begin
                sync1 <= i_data;
            end
            if (seq == USF_SEQ_SYNC2) begin
                sync2 <= i_data;
            end
        end
    end

    // Command register; error reset and internal reset are not kept
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd <= usf_cmd_t'(USF_CMD_RST);
        end else if (soft_rst) begin
            cmd <= usf_cmd_t'(USF_CMD_RST);
        end else if (ctl_wr && seq == USF_SEQ_CMD) begin
            cmd <= new_cmd;
            cmd.error_reset_bit    <= 1'b0;
            cmd.internal_reset_bit <= 1'b0;
        end
    end

    // Modem outputs follow command bits
    assign o_dtr_n = ~cmd.dtr;
    assign o_rts_n = ~cmd.rts;

    // ********************************************************
    // Mode decoding
    // ********************************************************
    logic        async_m;
    logic [3:0]  nbits;
    logic [5:0]  fac_m1;
    logic [5:0]  half_m1;
    logic        half_stop;
    logic        two_stop;

    assign async_m = (mode.factor != USF_FAC_SYNC);
    assign nbits   = USF_LEN_BASE + {2'h0, mode.len};
    assign half_m1 = fac_m1 >> 1;
    assign half_stop = async_m & (mode.stop == USF_STOP_HALF);
    assign two_stop  = async_m & mode.stop[1];

    // Bit-clock pulses per bit, less one
    always_comb begin
        case (mode.factor)
            USF_FAC_X1:   fac_m1 = USF_TICKS_X1;
            USF_FAC_X16:  fac_m1 = USF_TICKS_X16;
            USF_FAC_SYNC: fac_m1 = USF_TICKS_X1;
            default:      fac_m1 = USF_TICKS_X64;
        endcase
    end

    // ********************************************************
    // Transmit path
    // ********************************************************
    logic        f_valid;
    logic        f_ready;
    logic [7:0]  f_data;
    logic        pop;
    logic        can_send;
    logic        txc_q;
    logic        tx_tick;
    logic        tx_busy;
    logic [11:0] tx_sr;
    logic [11:0] next_sr;
    logic [3:0]  tx_left;
    logic [3:0]  next_left;
    logic [5:0]  tx_cnt;
    logic        par;
    logic [3:0]  pos;

    usf_fifo #(
        .W (USF_FIFO_W),
        .D (USF_FIFO_D)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_flush (soft_rst),
        .i_valid (dat_wr),
        .o_ready (f_ready),
        .i_data  (i_data),
        .o_valid (f_valid),
        .i_ready (pop),
        .o_data  (f_data)
    );

    assign can_send = cmd.tx_enable_bit & ~i_cts_n;
    // At one pulse per bit a load waits for a tick, so the start bit is whole
    assign pop      = f_valid & ~tx_busy & can_send
                    & (seq == USF_SEQ_CMD)
                    & (tx_tick | (fac_m1 != USF_TICKS_X1));
    assign tx_tick  = txc_q & ~i_tx_bit_clock_n;

    // Frame built LSB first: start, data, parity, stops in async mode; data and parity only in sync mode
    always_comb begin
        next_sr = 12'hFFF;
        pos     = async_m ? 4'h1 : 4'h0;
        par     = ^(f_data & ~(8'hFF << nbits)) ^ ~mode.even;
        next_sr[0] = ~async_m;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nbits) begin
                next_sr[pos + 4'(i)] = f_data[i];
            end
        end
        if (mode.par_en) begin
            next_sr[pos + nbits] = par;
        end
        next_left = pos + nbits + {3'h0, mode.par_en}
                  + (async_m ? 4'h1 : 4'h0)
                  + {3'h0, two_stop};
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            txc_q <= 1'b1;
        end else begin
            txc_q <= i_tx_bit_clock_n;
        end
    end

    // Shifter: one bit per factor ticks, last half stop shortened except at 1x
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_busy <= 1'b0;
            tx_sr   <= 12'hFFF;
            tx_left <= 4'h0;
            tx_cnt  <= 6'h00;
        end else if (soft_rst) begin
            tx_busy <= 1'b0;
            tx_sr   <= 12'hFFF;
        end else if (pop) begin
            tx_busy <= 1'b1;
            tx_sr   <= next_sr;
            tx_left <= next_left;
            tx_cnt  <= fac_m1;
        end else if (tx_busy && tx_tick) begin
            if (tx_cnt != 6'h00) begin
                tx_cnt <= tx_cnt - 6'h01;
            end else begin
                tx_sr   <= {1'b1, tx_sr[11:1]};
                tx_left <= tx_left - 4'h1;
                if (tx_left == 4'h2 && half_stop) begin
                    tx_cnt <= half_m1;
                end else begin
                    tx_cnt <= fac_m1;
                end
                if (tx_left == 4'h1) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    // Line driver: break low, else frame bit, else mark
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_txd <= 1'b1;
        end else if (cmd.send_break_bit) begin
            o_txd <= 1'b0;
        end else begin
            o_txd <= tx_busy ? tx_sr[0] : 1'b1;
        end
    end

    assign o_tx_shifter_empty = ~tx_busy;
    assign o_tx_buffer_ready  = f_ready & can_send
                              & (seq == USF_SEQ_CMD);

    // ********************************************************
    // Receive path
    // ********************************************************
    usf_rx_t     rx_st;
    logic        rxc_q;
    logic        rx_tick;
    logic        rxd_last;
    logic [5:0]  rx_cnt;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic        rx_done;
    logic        rx_stop_ok;
    logic        rx_par_bad;
    logic [7:0]  rx_buf;
    logic        rx_rdy;
    usf_status_t st;
    logic        pe_flag;
    logic        ov_flag;
    logic        fe_flag;

    assign rx_tick = ~rxc_q & i_rx_bit_clock_n;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rxc_q <= 1'b1;
        end else begin
            rxc_q <= i_rx_bit_clock_n;
        end
    end

    // Start hunt, centre check, then centred bit samples
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_st      <= USF_RX_IDLE;
            rxd_last   <= 1'b1;
            rx_cnt     <= 6'h00;
            rx_idx     <= 4'h0;
            rx_sh      <= 8'h00;
            rx_par     <= 1'b0;
            rx_done    <= 1'b0;
            rx_stop_ok <= 1'b0;
        end else if (soft_rst || seq != USF_SEQ_CMD || !async_m) begin
            rx_st   <= USF_RX_IDLE;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (rx_tick) begin
                rxd_last <= i_rxd;
                case (rx_st)
                    USF_RX_IDLE: begin
                        if (rxd_last && !i_rxd) begin
                            rx_st  <= USF_RX_START;
                            rx_cnt <= half_m1;
                            // One pulse per bit: this sample is the centre
                            if (fac_m1 == USF_TICKS_X1) begin
                                rx_st  <= USF_RX_BITS;
                                rx_cnt <= fac_m1;
                                rx_idx <= 4'h0;
                                rx_sh  <= 8'h00;
                            end
                        end
                    end
                    USF_RX_START: begin
                        if (rx_cnt != 6'h00) begin
                            rx_cnt <= rx_cnt - 6'h01;
                        end else if (!i_rxd) begin
                            rx_st  <= USF_RX_BITS;
                            rx_cnt <= fac_m1;
                            rx_idx <= 4'h0;
                            rx_sh  <= 8'h00;
                        end else begin
                            rx_st <= USF_RX_IDLE;
                        end
                    end
                    USF_RX_BITS: begin
                        if (rx_cnt != 6'h00) begin
                            rx_cnt <= rx_cnt - 6'h01;
                        end else begin
                            rx_cnt <= fac_m1;
                            rx_idx <= rx_idx + 4'h1;
                            if (rx_idx < nbits) begin
                                rx_sh[rx_idx[2:0]] <= i_rxd;
                            end else if (mode.par_en
                                         && rx_idx == nbits) begin
                                rx_par <= i_rxd;
                            end else begin
                                rx_done    <= 1'b1;
                                rx_stop_ok <= i_rxd;
                                rx_st      <= USF_RX_IDLE;
                            end
                        end
                    end
                    default: rx_st <= USF_RX_IDLE;
                endcase
            end
        end
    end

    assign rx_par_bad = mode.par_en
                      & (^rx_sh ^ rx_par ^ ~mode.even);

    // Receive buffer and ready; a new character beats a read
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_buf <= 8'h00;
            rx_rdy <= 1'b0;
        end else if (soft_rst) begin
            rx_rdy <= 1'b0;
        end else if (rx_done && rx_stop_ok) begin
            rx_buf <= rx_sh;
            rx_rdy <= 1'b1;
        end else if (rd_go && !i_cd) begin
            rx_rdy <= 1'b0;
        end
    end

    // Error flags: set wins over the error reset bit
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pe_flag <= 1'b0;
            ov_flag <= 1'b0;
            fe_flag <= 1'b0;
        end else if (soft_rst) begin
            pe_flag <= 1'b0;
            ov_flag <= 1'b0;
            fe_flag <= 1'b0;
        end else begin
            if (ctl_wr && seq == USF_SEQ_CMD
                && new_cmd.error_reset_bit) begin
                pe_flag <= 1'b0;
                ov_flag <= 1'b0;
                fe_flag <= 1'b0;
            end
            if (rx_done && rx_par_bad) begin
                pe_flag <= 1'b1;
            end
            if (rx_done && !rx_stop_ok) begin
                fe_flag <= 1'b1;
            end
            if (rx_done && rx_stop_ok && rx_rdy
                && !(rd_go && !i_cd)) begin
                ov_flag <= 1'b1;
            end
        end
    end

    assign o_rx_char_ready = rx_rdy & cmd.rx_ready_enable;

    // ********************************************************
    // Read data and status
    // ********************************************************
    assign st.dsr              = ~i_dsr_n;
    assign st.sync_det         = 1'b0;
    assign st.framing_error_flag = fe_flag;
    assign st.overrun_flag       = ov_flag;
    assign st.parity_error_flag  = pe_flag;
    assign st.tx_shifter_empty = ~tx_busy;
    assign st.rx_char_ready    = rx_rdy;
    assign st.tx_buffer_ready  = f_ready;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data <= 8'h00;
        end else if (rd_go) begin
            o_data <= i_cd ? 8'(st) : rx_buf;
        end
    end

    assign o_data_oe = rd_q & ~i_cs_n & ~i_rd_n;
endmodule

// File: tb/usf_core_assertions.sv
// Port checker for the serial transceiver core
`timescale 1ns/1ps
module usf_core_chk (
    input wire logic       i_clk, i_rstn, i_cs_n, i_rd_n, i_cd,
    input wire logic       i_cts_n, i_dsr_n, o_data_oe, o_txd,
    input wire logic       o_tx_buffer_ready, o_rx_char_ready,
    input wire logic       o_tx_shifter_empty,
    input wire logic [7:0] o_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Reset leaves the line marking and the ready flags low
    chk_reset_mark: assert property ($rose(i_rstn) |->
        o_txd && !o_tx_buffer_ready && !o_rx_char_ready)
        else $error("line or ready wrong after reset");
    chk_cts_ready: assert property (i_cts_n |-> !o_tx_buffer_ready)
        else $error("ready while clear-to-send high");
    chk_cts_noload: assert property (i_cts_n && o_tx_shifter_empty
        |=> o_tx_shifter_empty) else $error("load while send blocked");
    chk_start_low: assert property ($fell(o_tx_shifter_empty)
        |-> ##[0:1] !o_txd) else $error("no start bit after load");
    chk_read_clears: assert property ($fell(i_rd_n) && !i_cs_n
        && !i_cd |=> !o_rx_char_ready) else $error("rx ready not cleared");
    chk_oe_drive: assert property (!i_cs_n && !i_rd_n
        && $past(!i_cs_n && !i_rd_n) |-> o_data_oe)
        else $error("bus not driven in read");
    chk_oe_release: assert property (i_rd_n && $past(i_rd_n)
        |-> !o_data_oe) else $error("bus driven outside read");
    chk_status_dsr: assert property ($fell(i_rd_n) && !i_cs_n
        && i_cd |=> o_data[7] == !$past(i_dsr_n) && !o_data[6])
        else $error("status byte top bits wrong");
    // Main scenarios reached
    cover property ($rose(o_rx_char_ready));
    cover property ($rose(o_tx_buffer_ready));
    cover property (!o_txd && o_tx_shifter_empty);
endmodule
bind usf_core usf_core_chk u_chk (.*);

// File: tb/usf_line_model.sv
// Serial line partner: bit clock source and echoing far end
`timescale 1ns/1ps
module usf_line_model #(parameter int HALF = 2) (
    input  wire logic i_clk,
    input  wire logic i_txd,
    output logic      o_bit_clock_n,
    output logic      o_rxd
);
    int cnt = 0;
    // Free-running bit clock, HALF system cycles per level
    initial o_bit_clock_n = 1'b1;
    always @(posedge i_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) o_bit_clock_n <= ~o_bit_clock_n;
    end
    // Far end echoes the line, so framing and parity come back
    assign o_rxd = i_txd;
endmodule

// File: tb/usf_core_bench.sv
// Self-checking bench of the serial transceiver core
`timescale 1ns/1ps
module usf_core_bench;
    logic i_clk = 0, i_rstn, i_cs_n, i_rd_n, i_wr_n, i_cd, i_cts_n, i_dsr_n;
    logic [7:0] i_data, o_data;
    logic o_data_oe, o_tx_buffer_ready, o_rx_char_ready, o_tx_shifter_empty;
    logic o_txd, o_dtr_n, o_rts_n, i_rxd, bclk;
    int fail_count = 0, checked = 0, cyc = 0;
    usf_core dut (.*, .i_tx_bit_clock_n(bclk), .i_rx_bit_clock_n(bclk));
    usf_line_model line (.i_clk(i_clk), .i_txd(o_txd),
        .o_bit_clock_n(bclk), .o_rxd(i_rxd));
    always #4 i_clk = ~i_clk;
    // Cut a hang short
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One bus access: write when wr set, else read; read data lands in o_data
    task automatic acc(input logic wr, cd, input logic [7:0] d);
        @(posedge i_clk);
        i_cs_n <= 1'b0;
        i_cd <= cd;
        i_data <= d;
        if (wr) i_wr_n <= 1'b0;
        else i_rd_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_cs_n <= 1'b1;
        i_wr_n <= 1'b1;
        i_rd_n <= 1'b1;
        @(posedge i_clk);
        #1;
    endtask
    task automatic wait_rx();
        int n;
        for (n = 0; n < 3000 && o_rx_char_ready !== 1'b1; n++)
            @(posedge i_clk);
        if (n == 3000) chk("rx ready wait", 1, 0);
    endtask
    initial begin
        {i_rstn, i_cd, i_data, i_dsr_n} = '0;
        {i_cs_n, i_rd_n, i_wr_n, i_cts_n} = '1;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("idle line", 1, o_txd);
        acc(1, 1, 8'h4E);
        acc(1, 1, 8'h15);
        for (int i = 0; i < 17; i++) acc(1, 0, 8'h30 + i);
        acc(0, 1, 0);
        chk("status full", 8'h84, o_data);
        @(posedge i_clk) i_cts_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            wait_rx();
            acc(0, 0, 0);
            chk("rx data", 8'h30 + i, o_data);
            chk("rx ready", 0, o_rx_char_ready);
        end
        // Every length, both parities, stop codes 01, 10 and 11
        for (int l = 0; l < 4; l++) begin
            acc(1, 1, 8'h40);
            acc(1, 1, {2'(l % 3 + 1), 1'(l), 1'b1, 2'(l), 2'b10});
            acc(1, 1, 8'h15);
            chk("tx ready", 1, o_tx_buffer_ready);
            acc(1, 0, 8'hFF);
            wait_rx();
            acc(0, 0, 0);
            chk("short char", 8'hFF >> (3 - l), o_data);
            acc(0, 1, 0);
            chk("no errors", 0, o_data & 8'h38);
        end
        acc(1, 0, 8'h11);
        acc(1, 0, 8'h22);
        for (int n = 0; n < 60 && o_data[4] !== 1'b1; n++) begin
            repeat (20) @(posedge i_clk);
            acc(0, 1, 0);
        end
        chk("overrun", 1, o_data[4]);
        acc(0, 0, 0);
        chk("overwrite", 8'h22, o_data);
        acc(1, 1, 8'h15);
        acc(0, 1, 0);
        chk("flags cleared", 0, o_data & 8'h38);
        acc(1, 1, 8'h1D);
        repeat (3) @(posedge i_clk);
        #1;
        chk("break", 0, o_txd);
        acc(1, 1, 8'h15);
        repeat (3) @(posedge i_clk);
        #1;
        chk("mark", 1, o_txd);
        // Host-side init, then a one-sync mode: the sync must not act
        acc(1, 1, 8'h40);
        repeat (3) acc(1, 1, 8'h00);
        acc(1, 1, 8'h40);
        acc(1, 1, 8'h8C);
        acc(1, 1, 8'h02);
        chk("sync not command", 1, o_dtr_n);
        acc(1, 1, 8'h22);
        chk("dtr", 0, o_dtr_n);
        chk("rts", 0, o_rts_n);
        print_verdict();
    end
endmodule
